// ===== common/mmla_regs.svh
`ifndef MMLA_REGS_SVH
`define MMLA_REGS_SVH

// register byte offsets on the bus
`define MMLA_OFS_DEST 8'h00
`define MMLA_OFS_SRC 8'h04
`define MMLA_OFS_INSTR 8'h08
`define MMLA_OFS_RESULT 8'h0C
`define MMLA_OFS_FLAGS 8'h10
`define MMLA_OFS_STATUS 8'h14

// instruction codes of the four limit operations
`define MMLA_OP_MAX_U 6'h13
`define MMLA_OP_MAX_S 6'h11
`define MMLA_OP_MIN_U 6'h12
`define MMLA_OP_MIN_S 6'h10

// field positions
`define MMLA_FLAGS_Z_BIT 0
`define MMLA_FLAGS_C_BIT 1
`define MMLA_STAT_BUSY_BIT 0
`define MMLA_STAT_DONE_BIT 1
`define MMLA_STAT_WROTE_BIT 2
`define MMLA_STAT_BADOP_BIT 3

// reset values
`define MMLA_RST_WORD 32'h0000_0000
`define MMLA_RST_BIT 1'b0

// timing: cycles from instruction issue to completion
`define MMLA_EXEC_CYCLES 4

`endif

// ===== common/mmla_pkg.sv
package mmla_pkg;

	typedef struct packed {
		logic [5:0] opcode;
		logic zero_flag_write_effect;
		logic carry_flag_write_effect;
		logic write_result;
		logic imm;
		logic [3:0] cond;
		logic [8:0] dest_field;
		logic [8:0] src_field;
	} mmla_instr_s;

	typedef enum logic [4:0] {
		MMLA_IDLE = 5'h01,
		MMLA_DECODE = 5'h02,
		MMLA_OPERAND = 5'h04,
		MMLA_COMPARE = 5'h08,
		MMLA_WRITEBACK = 5'h10
	} mmla_state_e;

	typedef struct packed {
		logic bad_op;
		logic wrote;
		logic done;
		logic busy;
	} mmla_status_s;

	typedef struct packed {
		logic is_signed;
		logic take_greater;
	} mmla_kind_s;

endpackage

// ===== hw/mmla_compare.sv
`timescale 1ns/1ps
`default_nettype none

module mmla_compare #(
	parameter int WIDTH = 32
) (
	input wire logic [WIDTH-1:0] dest_in,
	input wire logic [WIDTH-1:0] src_in,
	input wire mmla_pkg::mmla_kind_s kind_in,
	output logic [WIDTH-1:0] result_out,
	output logic less_out,
	output logic zero_out
);

	wire less_u = dest_in < src_in;
	wire less_s = $signed(dest_in) < $signed(src_in);

	// one comparator serves both limit directions
	assign less_out = kind_in.is_signed ? less_s : less_u;
	// upper limit keeps the smaller, lower limit the larger
	assign result_out = (kind_in.take_greater ^ less_out) ? dest_in : src_in;
	assign zero_out = src_in == '0;

endmodule // mmla_compare

`default_nettype wire

// ===== hw/mmla_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmla_regs.svh"

module mmla_top #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [WIDTH-1:0] result_out,
	output logic result_we_out,
	output logic zero_flag_out,
	output logic carry_flag_out,
	output logic busy_out
);

	mmla_pkg::mmla_state_e st;
	mmla_pkg::mmla_state_e next_st;
	mmla_pkg::mmla_instr_s ins;
	mmla_pkg::mmla_kind_s kind;
	mmla_pkg::mmla_status_s stat;
	logic [WIDTH-1:0] dest_reg;
	logic [WIDTH-1:0] src_reg;
	logic [WIDTH-1:0] dest_op;
	logic [WIDTH-1:0] src_op;
	logic [WIDTH-1:0] cmp_res;
	logic cmp_less;
	logic cmp_zero;
	logic done;
	logic wrote;
	logic bad_op;

	// bus decode
	wire setup = psel_in && !penable_in;
	wire access = psel_in && penable_in && pready_out;
	wire hit_dest = paddr_in == `MMLA_OFS_DEST;
	wire hit_src = paddr_in == `MMLA_OFS_SRC;
	wire hit_instr = paddr_in == `MMLA_OFS_INSTR;
	wire hit_res = paddr_in == `MMLA_OFS_RESULT;
	wire hit_flags = paddr_in == `MMLA_OFS_FLAGS;
	wire hit_stat = paddr_in == `MMLA_OFS_STATUS;
	wire hit_any = hit_dest || hit_src || hit_instr || hit_res || hit_flags || hit_stat;
	wire hit_ro = hit_res || hit_stat;
	wire mmla_pkg::mmla_instr_s wins = pwdata_in;
	wire op_ok = wins.opcode == `MMLA_OP_MAX_U || wins.opcode == `MMLA_OP_MAX_S ||
		wins.opcode == `MMLA_OP_MIN_U || wins.opcode == `MMLA_OP_MIN_S;
	wire bad_instr = pwrite_in && hit_instr && !op_ok;
	// writes are refused while busy so software never races the datapath
	wire refuse = !hit_any || (pwrite_in && (hit_ro || busy_out)) || bad_instr;
	wire wr_ok = access && pwrite_in && !pslverr_out;
	wire instr_wr = wr_ok && hit_instr;
	wire bad_wr = access && pwrite_in && hit_instr && pslverr_out && !busy_out;
	wire idle = st == mmla_pkg::MMLA_IDLE;

	assign stat.busy = busy_out;
	assign stat.done = done;
	assign stat.wrote = wrote;
	assign stat.bad_op = bad_op;

	wire [31:0] flags_word = {30'h0, carry_flag_out, zero_flag_out};
	wire [31:0] rd_data = hit_dest ? dest_reg :
		hit_src ? src_reg :
		hit_instr ? ins :
		hit_res ? result_out :
		hit_flags ? flags_word :
		hit_stat ? {28'h0, stat} : `MMLA_RST_WORD;

	// operand select and decode
	wire [WIDTH-1:0] imm_ext = {{(WIDTH-9){1'b0}}, ins.src_field};
	wire [WIDTH-1:0] next_src_op = ins.imm ? imm_ext : src_reg;
	wire next_signed = ins.opcode == `MMLA_OP_MAX_S || ins.opcode == `MMLA_OP_MIN_S;
	wire next_greater = ins.opcode == `MMLA_OP_MIN_U || ins.opcode == `MMLA_OP_MIN_S;

	logic [WIDTH-1:0] alu_res;
	logic alu_less;
	logic alu_zero;

	mmla_compare #(
		.WIDTH(WIDTH)
	) u_compare (
		.dest_in(dest_op),
		.src_in(src_op),
		.kind_in(kind),
		.result_out(alu_res),
		.less_out(alu_less),
		.zero_out(alu_zero)
	);

	// four fixed stages, no early exit
	always_comb begin
		case (st)
			mmla_pkg::MMLA_IDLE: next_st = instr_wr ? mmla_pkg::MMLA_DECODE : mmla_pkg::MMLA_IDLE;
			mmla_pkg::MMLA_DECODE: next_st = mmla_pkg::MMLA_OPERAND;
			mmla_pkg::MMLA_OPERAND: next_st = mmla_pkg::MMLA_COMPARE;
			mmla_pkg::MMLA_COMPARE: next_st = mmla_pkg::MMLA_WRITEBACK;
			mmla_pkg::MMLA_WRITEBACK: next_st = mmla_pkg::MMLA_IDLE;
			default: next_st = mmla_pkg::MMLA_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			st <= mmla_pkg::MMLA_IDLE;
			busy_out <= `MMLA_RST_BIT;
		end else begin
			st <= next_st;
			busy_out <= next_st != mmla_pkg::MMLA_IDLE;
		end
	end

	// bus slave: answer prepared in setup, zero wait states
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			pready_out <= `MMLA_RST_BIT;
			pslverr_out <= `MMLA_RST_BIT;
			prdata_out <= `MMLA_RST_WORD;
		end else begin
			pready_out <= setup;
			pslverr_out <= setup && refuse;
			prdata_out <= (setup && !pwrite_in) ? rd_data : `MMLA_RST_WORD;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			dest_reg <= `MMLA_RST_WORD;
			src_reg <= `MMLA_RST_WORD;
			ins <= `MMLA_RST_WORD;
		end else if (wr_ok) begin
			if (hit_dest) dest_reg <= pwdata_in;
			if (hit_src) src_reg <= pwdata_in;
			if (hit_instr) ins <= pwdata_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			kind <= '0;
			dest_op <= `MMLA_RST_WORD;
			src_op <= `MMLA_RST_WORD;
			cmp_res <= `MMLA_RST_WORD;
			cmp_less <= `MMLA_RST_BIT;
			cmp_zero <= `MMLA_RST_BIT;
		end else begin
			if (st == mmla_pkg::MMLA_DECODE) kind <= '{next_signed, next_greater};
			if (st == mmla_pkg::MMLA_OPERAND) begin
				dest_op <= dest_reg;
				src_op <= next_src_op;
			end
			if (st == mmla_pkg::MMLA_COMPARE) begin
				cmp_res <= alu_res;
				cmp_less <= alu_less;
				cmp_zero <= alu_zero;
			end
		end
	end

	wire wb = st == mmla_pkg::MMLA_WRITEBACK;
	wire flags_sw = wr_ok && hit_flags;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			result_out <= `MMLA_RST_WORD;
			result_we_out <= `MMLA_RST_BIT;
		end else begin
			result_we_out <= wb && ins.write_result;
			if (wb && ins.write_result) result_out <= cmp_res;
		end
	end

	// flags move only with their effect bit or a software write
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			zero_flag_out <= `MMLA_RST_BIT;
			carry_flag_out <= `MMLA_RST_BIT;
		end else if (wb) begin
			if (ins.zero_flag_write_effect) zero_flag_out <= cmp_zero;
			if (ins.carry_flag_write_effect) carry_flag_out <= cmp_less;
		end else if (flags_sw) begin
			zero_flag_out <= pwdata_in[`MMLA_FLAGS_Z_BIT];
			carry_flag_out <= pwdata_in[`MMLA_FLAGS_C_BIT];
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			done <= `MMLA_RST_BIT;
			wrote <= `MMLA_RST_BIT;
			bad_op <= `MMLA_RST_BIT;
		end else begin
			if (instr_wr) begin
				done <= 1'b0;
				wrote <= 1'b0;
				bad_op <= 1'b0;
			end else if (wb) begin
				done <= 1'b1;
				wrote <= ins.write_result;
			end
			if (bad_wr) bad_op <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	sequence s_issue;
		idle && instr_wr;
	endsequence

	sequence s_run;
		busy_out [*4] ##1 (!busy_out && done);
	endsequence

	sequence s_wb_max_u;
		wb && ins.opcode == `MMLA_OP_MAX_U && ins.write_result;
	endsequence

	chk_umax_smaller: assert property (s_wb_max_u |=> result_we_out &&
		result_out == ((dest_op < src_op) ? dest_op : src_op))
		else $error("unsigned upper limit result wrong");

	chk_smax_smaller: assert property (wb && ins.opcode == `MMLA_OP_MAX_S && ins.write_result
		|=> result_out == (($signed(dest_op) < $signed(src_op)) ? dest_op : src_op))
		else $error("signed upper limit result wrong");

	chk_umin_larger: assert property (wb && ins.opcode == `MMLA_OP_MIN_U && ins.write_result
		|=> result_out == ((dest_op < src_op) ? src_op : dest_op))
		else $error("unsigned lower limit result wrong");

	chk_smin_larger: assert property (wb && ins.opcode == `MMLA_OP_MIN_S && ins.write_result
		|=> result_out == (($signed(dest_op) < $signed(src_op)) ? src_op : dest_op))
		else $error("signed lower limit result wrong");

	chk_zero_flag_src: assert property (wb && ins.zero_flag_write_effect
		|=> zero_flag_out == (src_op == '0))
		else $error("zero flag does not follow source");

	chk_carry_unsigned: assert property (wb && ins.carry_flag_write_effect && !kind.is_signed
		|=> carry_flag_out == (dest_op < src_op))
		else $error("unsigned carry wrong");

	chk_carry_signed: assert property (wb && ins.carry_flag_write_effect && kind.is_signed
		|=> carry_flag_out == ($signed(dest_op) < $signed(src_op)))
		else $error("signed carry wrong");

	chk_no_result_write: assert property (wb && !ins.write_result
		|=> !result_we_out && $stable(result_out))
		else $error("result written despite suppression");

	chk_imm_zero_ext: assert property (st == mmla_pkg::MMLA_OPERAND && ins.imm
		|=> src_op == {{(WIDTH-9){1'b0}}, ins.src_field})
		else $error("immediate source not zero-extended");

	chk_decode_kind: assert property (st == mmla_pkg::MMLA_DECODE
		|=> kind.is_signed == !ins.opcode[1] && kind.take_greater == !ins.opcode[0])
		else $error("limit kind decoded wrong");

	chk_four_cycles: assert property (s_issue |=> s_run)
		else $error("instruction did not complete in four cycles");

	chk_flag_hold: assert property (wb && !ins.zero_flag_write_effect && !ins.carry_flag_write_effect
		|=> $stable(zero_flag_out) && $stable(carry_flag_out))
		else $error("flag changed without its effect");

endmodule // mmla_top

`default_nettype wire

// ===== sim/mmla_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// apb master standing in for the core's decoder and register file
module mmla_core_model (
	input wire logic clk_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0000_0000;
	end

	// enter just after a rising edge; returns one idle cycle after the edge that took the answer
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
			output logic [31:0] rdata, output logic err, output logic timed_out);
		int n;
		n = 0;
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= addr;
		pwdata_out <= data;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// the answer is registered, so right after the edge we still see what that edge sampled
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_in !== 1'b1 && n < 64);
		rdata = prdata_in;
		err = pslverr_in;
		timed_out = (pready_in !== 1'b1);
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// released lines must not keep showing the old request
		paddr_out <= ~addr;
		pwdata_out <= ~data;
		// one idle cycle, so a following call never drives these lines twice in one step
		@(posedge clk_in);
	endtask
endmodule // mmla_core_model

`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmla_regs.svh"

module tb_top;
	logic clk_sys_in, reset_in, psel, penable, pwrite, pready, pslverr, result_we, zero_flag, carry_flag, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, result;
	int mismatches = 0;
	int n_compared = 0;
	logic [15:0] lfsr = 16'h0010;
	logic zf = 1'b0;
	logic cf = 1'b0;
	logic [31:0] last_res = 32'h0000_0000;
	logic [5:0] ops [4] = '{`MMLA_OP_MAX_U, `MMLA_OP_MAX_S, `MMLA_OP_MIN_U, `MMLA_OP_MIN_S};
	logic [31:0] dv [7] = '{32'h1, 32'h1, 32'h1, 32'hFFFF_FFFF, 32'h2, 32'h8000_0000, 32'h0};
	logic [31:0] sv [7] = '{32'hFFFF_FFFF, 32'h0, 32'h2, 32'h1, 32'h1, 32'h7FFF_FFFF, 32'h1};

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	mmla_top u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .result_out(result), .result_we_out(result_we), .zero_flag_out(zero_flag),
		.carry_flag_out(carry_flag), .busy_out(busy));

	mmla_core_model u_core (.clk_in(clk_sys_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
		.paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic exp_err,
			output logic [31:0] rd);
		logic err, to;
		u_core.xfer(wr, a, d, rd, err, to);
		check({31'h0, to}, 32'h0, "bus timeout");
		check({31'h0, err}, {31'h0, exp_err}, "pslverr");
	endtask

	function automatic logic [15:0] step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic logic [31:0] rnd32();
		logic [15:0] hi;
		lfsr = step(lfsr);
		hi = lfsr;
		lfsr = step(lfsr);
		return {hi, lfsr};
	endfunction

	// returns {dest below source, limited value}
	function automatic logic [32:0] limit(input logic [5:0] op, input logic [31:0] d, input logic [31:0] s);
		logic lt;
		lt = op[1] ? (d < s) : ($signed(d) < $signed(s));
		if (op[0]) begin
			return {lt, lt ? d : s};
		end
		return {lt, lt ? s : d};
	endfunction

	// fx is {zero effect, carry effect, write result, immediate}
	task automatic run_op(input logic [5:0] op, input logic [3:0] fx, input logic [31:0] d,
			input logic [31:0] s, input logic [8:0] s9);
		logic [31:0] rd, src;
		logic [32:0] e;
		bus(1'b1, `MMLA_OFS_DEST, d, 1'b0, rd);
		bus(1'b1, `MMLA_OFS_SRC, s, 1'b0, rd);
		src = fx[0] ? {23'h0, s9} : s;
		e = limit(op, d, src);
		bus(1'b1, `MMLA_OFS_INSTR, {op, fx, 4'hF, 9'h000, s9}, 1'b0, rd);
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		check({31'h0, busy}, 32'h1, "busy mid");
		check({31'h0, result_we}, 32'h0, "early write");
		@(negedge clk_sys_in);
		if (fx[3]) zf = (src == 32'h0);
		if (fx[2]) cf = e[32];
		if (fx[1]) last_res = e[31:0];
		check({31'h0, result_we}, {31'h0, fx[1]}, "write pulse");
		check(result, last_res, "result");
		check({30'h0, carry_flag, zero_flag}, {30'h0, cf, zf}, "flags");
		check({31'h0, busy}, 32'h0, "busy end");
		@(posedge clk_sys_in);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_in);
		mismatches++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		logic [31:0] rd, r, d, s, s9;
		reset_in = 1'b1;
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		for (int a = 0; a < 6; a++) begin
			bus(1'b0, 8'(a * 4), 32'h0, 1'b0, rd);
			check(rd, `MMLA_RST_WORD, "reset value");
		end
		$display("test reset values done");
		foreach (ops[i]) foreach (dv[j]) run_op(ops[i], 4'hE, dv[j], sv[j], 9'h000);
		run_op(`MMLA_OP_MIN_S, 4'hF, 32'hFFFF_FFFF, 32'h0, 9'h1FF);
		$display("test corner cases done");
		for (int k = 0; k < 200; k++) begin
			r = rnd32();
			if (r[7]) begin
				bus(1'b1, `MMLA_OFS_FLAGS, {30'h0, r[9:8]}, 1'b0, rd);
				zf = r[8];
				cf = r[9];
			end
			d = rnd32();
			s = rnd32();
			s9 = rnd32();
			run_op(ops[r[1:0]], r[5:2], d, s, s9[8:0]);
		end
		$display("test random operations done");
		bus(1'b1, `MMLA_OFS_INSTR, {6'h20, 26'h0}, 1'b1, rd);
		bus(1'b0, `MMLA_OFS_STATUS, 32'h0, 1'b0, rd);
		check({31'h0, rd[`MMLA_STAT_BADOP_BIT]}, 32'h1, "bad opcode flag");
		bus(1'b0, 8'h18, 32'h0, 1'b1, rd);
		check(rd, 32'h0, "unmapped read");
		bus(1'b1, `MMLA_OFS_RESULT, rnd32(), 1'b1, rd);
		bus(1'b1, `MMLA_OFS_DEST, 32'h55, 1'b0, rd);
		bus(1'b1, `MMLA_OFS_INSTR, {`MMLA_OP_MAX_U, 26'h0}, 1'b0, rd);
		bus(1'b1, `MMLA_OFS_DEST, 32'hAA, 1'b1, rd);
		repeat (6) @(posedge clk_sys_in);
		bus(1'b0, `MMLA_OFS_DEST, 32'h0, 1'b0, rd);
		check(rd, 32'h55, "write while busy");
		$display("test refusals done");
		tally_and_finish();
	end
endmodule // tb_top

`default_nettype wire
